/* light_prox_pkg.sv */
// Constants for the light and proximity control and interrupt block.
// Assumes a 250 MHz system clock; all cycle counts below derive from it.
package light_prox_pkg;
   // Register indices on the serial port
   localparam logic [3:0] REG_CHIP = 4'h0;
   localparam logic [3:0] REG_CFG  = 4'h1;
   localparam logic [3:0] REG_INT  = 4'h2;
   localparam logic [3:0] REG_PTL  = 4'h3;
   localparam logic [3:0] REG_PTH  = 4'h4;
   localparam logic [3:0] REG_LTH1 = 4'h5;
   localparam logic [3:0] REG_LTH2 = 4'h6;
   localparam logic [3:0] REG_LTH3 = 4'h7;
   localparam logic [3:0] REG_PDAT = 4'h8;
   localparam logic [3:0] REG_LDT1 = 4'h9;
   localparam logic [3:0] REG_LDT2 = 4'hA;
   localparam logic [3:0] REG_LAST = REG_LDT2;
   // Reset values
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [7:0] INT_RST  = 8'h00;
   localparam logic [7:0] PTL_RST  = 8'h00;
   localparam logic [7:0] PTH_RST  = 8'hFF;
   localparam logic [7:0] LTH1_RST = 8'h00;
   localparam logic [7:0] LTH2_RST = 8'hF0;
   localparam logic [7:0] LTH3_RST = 8'hFF;
   // Field positions
   localparam int CFG_SPECTRUM_B = 0;
   localparam int CFG_RANGE_B    = 1;
   localparam int CFG_LIGHT_EN_B = 2;
   localparam int CFG_LED_DR_B   = 3;
   localparam int CFG_SLEEP_LSB  = 4;
   localparam int CFG_PROX_EN_B  = 7;
   localparam int INT_CTRL_B     = 0;
   localparam int INT_LPERS_LSB  = 1;
   localparam int INT_LFLAG_B    = 3;
   localparam int INT_RSVD_B     = 4;
   localparam int INT_NPERS_LSB  = 5;
   localparam int INT_NFLAG_B    = 7;
   // Serial port
   localparam logic [6:0] DEV_ADDR = 7'h44;
   localparam logic [3:0] BIT_ACK  = 4'h8;
   localparam logic [3:0] BIT_END  = 4'h9;
   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 4;
   localparam int unsigned PROX_CONV_NS    = 540000;
   localparam int unsigned LIGHT_INTEG_MS  = 100;
   localparam int unsigned SLEEP_UNIT_NS   = 100000;
   localparam int unsigned PROX_CONV_CYCLES  = PROX_CONV_NS / CLK_PERIOD_NS;
   localparam int unsigned LIGHT_INTEG_CYCLES = LIGHT_INTEG_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned SLEEP_UNIT_CYCLES = SLEEP_UNIT_NS / CLK_PERIOD_NS;
   // Sleep time per code, in units of 100 us (800 ms down to 0)
   localparam int unsigned SLEEP_UNITS [8] = '{8000, 4000, 2000, 1000, 750, 500, 125, 0};
   // Persistence counts per code
   localparam logic [4:0] PERS_N [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
   localparam logic [4:0] PERS_MAX = 5'h10;
   typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_WR, I_RD} serial_state_t;
   typedef enum logic [1:0] {P_OFF, P_CONV, P_SLEEP} prox_state_t;
endpackage : light_prox_pkg

/* light_prox_ctrl.sv */
// Control, sequencing and interrupt logic of a light and proximity sensor,
// with its two-wire serial register port.
// Assumes analog results are stable on the result inputs at conversion end.
// Behaviour
// - Data select picks visible or infrared result
// - Range bit picks 200 or 3200 lux
// - One enable runs both light conversions
// - Drive bit picks 110mA or 220mA pulses
// - Sleep code sets idle between proximity conversions
// - Enabled proximity converts 0.54ms then sleeps
// - Proximity enable starts conversion cycle, resets off
// - Combine bit chooses OR or AND
// - Open-drain interrupt low while combination true
// - Host writing zero clears flag
// - Light persistence needs 1/4/8/16 runs
// - Light flag sets outside window, sticky
// - Proximity persistence needs 1/4/8/16 near runs
// - Proximity flag clears by host or far run
// - Result at or below low is far
// - Result at or above high is near
// - Light window uses 12-bit inclusive thresholds
// - Light integrates 100ms, persistence per integration
`timescale 1ns/100ps
module light_prox_ctrl
   import light_prox_pkg::*;
#(
   parameter int unsigned PROX_CONV_CYC   = PROX_CONV_CYCLES,
   parameter int unsigned LIGHT_INTEG_CYC = LIGHT_INTEG_CYCLES,
   parameter int unsigned SLEEP_UNIT_CYC  = SLEEP_UNIT_CYCLES,
   parameter logic [7:0]  CHIP_ID         = 8'h5A   // Arbitrary value
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   input  wire logic        CE_I,
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE_O,
   output logic             INT_O,
   output logic             INT_OE_O,
   input  wire logic [7:0]  PROX_RESULT_I,
   input  wire logic [11:0] LIGHT_VIS_I,
   input  wire logic [11:0] LIGHT_IR_I,
   output logic             LIGHT_ENABLE_O,
   output logic             LIGHT_RANGE_O,
   output logic             LIGHT_SPECTRUM_O,
   output logic             LED_DRIVE_STRENGTH_O,
   output logic             LED_PULSE_O
);
   logic [1:0]    scl_s_q, sda_s_q;
   logic          scl_p_q, sda_p_q;
   serial_state_t ist_q, ist_d;
   prox_state_t   pst_q, pst_d;
   logic [3:0]    bit_q, bit_d, ptr_q, ptr_d;
   logic [7:0]    sh_q, sh_d, tx_q, tx_d, rd_byte;
   logic          sda_oe_q, sda_oe_d, nack_q, nack_d, int_q, int_d;
   logic [7:0]    cfg_q, cfg_d, irq_q, irq_d, ptl_q, ptl_d, pth_q, pth_d;
   logic [7:0]    lth1_q, lth1_d, lth2_q, lth2_d, lth3_q, lth3_d, pdat_q, pdat_d;
   logic [11:0]   ldat_q, ldat_d, lval, lt, ht;
   logic [27:0]   pcnt_q, pcnt_d, lcnt_q, lcnt_d, sleep_cyc;
   logic [4:0]    ncnt_q, ncnt_d, fcnt_q, fcnt_d, lev_q, lev_d;
   logic          scl, sda, scl_rise, scl_fall, start, stop, wr_en;
   logic          prox_en, light_en, p_done, l_done, near, far, l_out;

   function automatic logic [3:0] next_ptr(input logic [3:0] p);
      next_ptr = (p >= REG_LAST) ? REG_CHIP : p + 4'h1;
   endfunction : next_ptr

   function automatic logic [4:0] bump(input logic [4:0] c);
      bump = (c >= PERS_MAX) ? c : c + 5'h01;
   endfunction : bump

   // Two-stage synchronisers, then a delayed copy for edges
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else if (CE_I) begin
         scl_s_q <= {scl_s_q[0], SCL_I};
         sda_s_q <= {sda_s_q[0], SDA_I};
         scl_p_q <= scl_s_q[1];
         sda_p_q <= sda_s_q[1];
      end
   end

   assign scl      = scl_s_q[1];
   assign sda      = sda_s_q[1];
   assign scl_rise = scl && !scl_p_q;
   assign scl_fall = !scl && scl_p_q;
   assign start    = scl && scl_p_q && sda_p_q && !sda;
   assign stop     = scl && scl_p_q && !sda_p_q && sda;
   assign prox_en  = cfg_q[CFG_PROX_EN_B];
   assign light_en = cfg_q[CFG_LIGHT_EN_B];
   assign lt       = {lth2_q[3:0], lth1_q};
   assign ht       = {lth3_q, lth2_q[7:4]};
   assign sleep_cyc = 28'(SLEEP_UNITS[cfg_q[CFG_SLEEP_LSB +: 3]] * SLEEP_UNIT_CYC);
   assign p_done   = (pst_q == P_CONV) && (pcnt_q == 28'(PROX_CONV_CYC - 1));
   assign l_done   = light_en && (lcnt_q == 28'(LIGHT_INTEG_CYC - 1));
   assign lval     = cfg_q[CFG_SPECTRUM_B] ? LIGHT_IR_I : LIGHT_VIS_I;
   assign near     = PROX_RESULT_I >= pth_q;
   assign far      = PROX_RESULT_I <= ptl_q;
   assign l_out    = (lval <= lt) || (lval >= ht);

   // Register read mux; unmapped indices read zero
   always_comb begin
      case (ptr_q)
         REG_CHIP: rd_byte = CHIP_ID;
         REG_CFG:  rd_byte = cfg_q;
         REG_INT:  rd_byte = irq_q;
         REG_PTL:  rd_byte = ptl_q;
         REG_PTH:  rd_byte = pth_q;
         REG_LTH1: rd_byte = lth1_q;
         REG_LTH2: rd_byte = lth2_q;
         REG_LTH3: rd_byte = lth3_q;
         REG_PDAT: rd_byte = pdat_q;
         REG_LDT1: rd_byte = ldat_q[7:0];
         REG_LDT2: rd_byte = {4'h0, ldat_q[11:8]};
         default:  rd_byte = 8'h00;
      endcase
   end

   always_comb begin
      ist_d = ist_q;  bit_d = bit_q;  sh_d = sh_q;  tx_d = tx_q;  ptr_d = ptr_q;
      sda_oe_d = sda_oe_q;  nack_d = nack_q;  wr_en = 1'b0;
      cfg_d = cfg_q;  irq_d = irq_q;  ptl_d = ptl_q;  pth_d = pth_q;
      lth1_d = lth1_q;  lth2_d = lth2_q;  lth3_d = lth3_q;
      pst_d = pst_q;  pcnt_d = pcnt_q;  lcnt_d = lcnt_q;  pdat_d = pdat_q;  ldat_d = ldat_q;
      ncnt_d = ncnt_q;  fcnt_d = fcnt_q;  lev_d = lev_q;
      // Serial slave
      if (start) begin
         ist_d = I_DEV;  bit_d = 4'h0;  sda_oe_d = 1'b0;
      end else if (stop) begin
         ist_d = I_IDLE;  sda_oe_d = 1'b0;
      end else if (ist_q != I_IDLE) begin
         if (scl_rise) begin
            if (bit_q < BIT_ACK) sh_d = {sh_q[6:0], sda};
            else nack_d = sda;
            bit_d = bit_q + 4'h1;
         end else if (scl_fall) begin
            if (bit_q == BIT_ACK) begin
               case (ist_q)
                  I_DEV: begin
                     if (sh_q[7:1] == DEV_ADDR) sda_oe_d = 1'b1;
                     else ist_d = I_IDLE;
                  end
                  I_REG: begin
                     sda_oe_d = 1'b1;
                     ptr_d = sh_q[3:0];
                  end
                  I_WR: begin
                     sda_oe_d = 1'b1;
                     wr_en = 1'b1;
                     ptr_d = next_ptr(ptr_q);
                  end
                  default: sda_oe_d = 1'b0;
               endcase
            end else if (bit_q == BIT_END) begin
               bit_d = 4'h0;
               sda_oe_d = 1'b0;
               case (ist_q)
                  I_DEV, I_RD: begin
                     if ((ist_q == I_DEV && !sh_q[0]) || (ist_q == I_RD && nack_q)) begin
                        ist_d = (ist_q == I_DEV) ? I_REG : I_IDLE;
                     end else begin
                        ist_d = I_RD;
                        tx_d = rd_byte;
                        ptr_d = next_ptr(ptr_q);
                        sda_oe_d = !rd_byte[7];
                     end
                  end
                  I_REG:   ist_d = I_WR;
                  default: ist_d = ist_q;
               endcase
            end else if (ist_q == I_RD) begin
               sda_oe_d = !tx_q[3'h7 - bit_q[2:0]];
            end
         end
      end
      // Register writes
      if (wr_en) begin
         case (ptr_q)
            REG_CFG:  cfg_d = sh_q;
            REG_INT: begin
               irq_d = sh_q & irq_q | ~(8'h01 << INT_LFLAG_B | 8'h01 << INT_NFLAG_B) & sh_q;
               irq_d[INT_RSVD_B] = 1'b0;
            end
            REG_PTL:  ptl_d = sh_q;
            REG_PTH:  pth_d = sh_q;
            REG_LTH1: lth1_d = sh_q;
            REG_LTH2: lth2_d = sh_q;
            REG_LTH3: lth3_d = sh_q;
            default:  cfg_d = cfg_q;
         endcase
      end
      // Proximity sequencer
      case (pst_q)
         P_OFF: begin
            pcnt_d = 28'h0;
            if (prox_en) pst_d = P_CONV;
         end
         P_CONV: begin
            if (!prox_en) begin
               pst_d = P_OFF;
               pcnt_d = 28'h0;
            end else if (p_done) begin
               pcnt_d = 28'h0;
               pst_d = (sleep_cyc == 28'h0) ? P_CONV : P_SLEEP;
               pdat_d = PROX_RESULT_I;
               ncnt_d = near ? bump(ncnt_q) : 5'h00;
               fcnt_d = far ? bump(fcnt_q) : 5'h00;
               if (fcnt_d >= PERS_N[irq_q[INT_NPERS_LSB +: 2]])
                  irq_d[INT_NFLAG_B] = 1'b0;
               if (ncnt_d >= PERS_N[irq_q[INT_NPERS_LSB +: 2]])
                  irq_d[INT_NFLAG_B] = 1'b1;
            end else begin
               pcnt_d = pcnt_q + 28'h1;
            end
         end
         P_SLEEP: begin
            if (!prox_en) begin
               pst_d = P_OFF;
               pcnt_d = 28'h0;
            end else if ((sleep_cyc == 28'h0) || (pcnt_q >= sleep_cyc - 28'h1)) begin
               pst_d = P_CONV;
               pcnt_d = 28'h0;
            end else begin
               pcnt_d = pcnt_q + 28'h1;
            end
         end
         default: pst_d = P_OFF;
      endcase
      // Light integration
      if (!light_en) begin
         lcnt_d = 28'h0;
      end else if (l_done) begin
         lcnt_d = 28'h0;
         ldat_d = lval;
         lev_d = l_out ? bump(lev_q) : 5'h00;
         if (lev_d >= PERS_N[irq_q[INT_LPERS_LSB +: 2]])
            irq_d[INT_LFLAG_B] = 1'b1;
      end else begin
         lcnt_d = lcnt_q + 28'h1;
      end
      int_d = irq_d[INT_CTRL_B] ? (irq_d[INT_LFLAG_B] && irq_d[INT_NFLAG_B])
                                : (irq_d[INT_LFLAG_B] || irq_d[INT_NFLAG_B]);
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         ist_q <= I_IDLE;  bit_q <= 4'h0;  sh_q <= 8'h00;  tx_q <= 8'h00;  ptr_q <= REG_CHIP;
         sda_oe_q <= 1'b0;  nack_q <= 1'b0;  int_q <= 1'b0;
         cfg_q <= CFG_RST;  irq_q <= INT_RST;  ptl_q <= PTL_RST;  pth_q <= PTH_RST;
         lth1_q <= LTH1_RST;  lth2_q <= LTH2_RST;  lth3_q <= LTH3_RST;
         pst_q <= P_OFF;  pcnt_q <= 28'h0;  lcnt_q <= 28'h0;  pdat_q <= 8'h00;  ldat_q <= 12'h000;
         ncnt_q <= 5'h00;  fcnt_q <= 5'h00;  lev_q <= 5'h00;
      end else if (CE_I) begin
         ist_q <= ist_d;  bit_q <= bit_d;  sh_q <= sh_d;  tx_q <= tx_d;  ptr_q <= ptr_d;
         sda_oe_q <= sda_oe_d;  nack_q <= nack_d;  int_q <= int_d;
         cfg_q <= cfg_d;  irq_q <= irq_d;  ptl_q <= ptl_d;  pth_q <= pth_d;
         lth1_q <= lth1_d;  lth2_q <= lth2_d;  lth3_q <= lth3_d;
         pst_q <= pst_d;  pcnt_q <= pcnt_d;  lcnt_q <= lcnt_d;  pdat_q <= pdat_d;  ldat_q <= ldat_d;
         ncnt_q <= ncnt_d;  fcnt_q <= fcnt_d;  lev_q <= lev_d;
      end
   end

   assign SDA_O    = 1'b0;
   assign SDA_OE_O = sda_oe_q;
   assign INT_O    = 1'b0;
   assign INT_OE_O = int_q;
   // Range: 0 = 200 lux, 1 = 3200 lux full scale
   assign LIGHT_RANGE_O        = cfg_q[CFG_RANGE_B];
   assign LIGHT_ENABLE_O       = light_en;
   assign LIGHT_SPECTRUM_O     = cfg_q[CFG_SPECTRUM_B];
   // Drive: 0 = 110mA, 1 = 220mA pulsed sink
   assign LED_DRIVE_STRENGTH_O = cfg_q[CFG_LED_DR_B];
   assign LED_PULSE_O          = (pst_q == P_CONV);

   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_prox_done;
      CE_I && prox_en && p_done;
   endsequence
   sequence s_near_once;
      s_prox_done ##0 (near && irq_q[INT_NPERS_LSB +: 2] == 2'h0);
   endsequence

   property p_spectrum;
      CE_I && l_done && cfg_q[CFG_SPECTRUM_B] |=> ldat_q == $past(LIGHT_IR_I);
   endproperty
   a_spectrum: assert property (p_spectrum) else $error("IR result not routed");
   property p_light_off;
      CE_I && !light_en |=> lcnt_q == 28'h0;
   endproperty
   a_light_off: assert property (p_light_off) else $error("Light ran while off");
   property p_prox_off;
      CE_I && !prox_en |=> pst_q == P_OFF;
   endproperty
   a_prox_off: assert property (p_prox_off) else $error("Proximity ran while off");
   property p_no_sleep;
      s_prox_done ##0 (cfg_q[CFG_SLEEP_LSB +: 3] == 3'h7) |=> pst_q == P_CONV;
   endproperty
   a_no_sleep: assert property (p_no_sleep) else $error("Slept in continuous mode");
   property p_int_combine;
      INT_OE_O == (irq_q[INT_CTRL_B] ? (irq_q[INT_LFLAG_B] && irq_q[INT_NFLAG_B])
                                     : (irq_q[INT_LFLAG_B] || irq_q[INT_NFLAG_B]));
   endproperty
   a_int_combine: assert property (p_int_combine) else $error("Bad interrupt level");
   property p_near_set;
      s_near_once |=> irq_q[INT_NFLAG_B];
   endproperty
   a_near_set: assert property (p_near_set) else $error("Near flag not set");
   property p_far_clear;
      s_prox_done ##0 (far && !near && irq_q[INT_NPERS_LSB +: 2] == 2'h0) |=> !irq_q[INT_NFLAG_B];
   endproperty
   a_far_clear: assert property (p_far_clear) else $error("Far did not clear");
   property p_run_reset;
      s_prox_done ##0 !near |=> ncnt_q == 5'h00;
   endproperty
   a_run_reset: assert property (p_run_reset) else $error("Run counter kept");
   property p_light_set;
      CE_I && l_done && l_out && irq_q[INT_LPERS_LSB +: 2] == 2'h0 |=> irq_q[INT_LFLAG_B];
   endproperty
   a_light_set: assert property (p_light_set) else $error("Light flag not set");
   property p_host_clear;
      CE_I && wr_en && ptr_q == REG_INT && !sh_q[INT_LFLAG_B] && !l_done |=> !irq_q[INT_LFLAG_B];
   endproperty
   a_host_clear: assert property (p_host_clear) else $error("Host clear lost");
endmodule : light_prox_ctrl

/* light_prox_host.sv */
// Host model: bit-level two-wire master for the light and proximity block.
// Assumes the bench forms the SDA wire from both pull-down enables and a pull-up.
`timescale 1ns/100ps
module light_prox_host
   import light_prox_pkg::*;
(
   input  wire logic CLK_I,
   input  wire logic SDA_I,
   output logic      SCL_O    = 1'b1,
   output logic      SDA_OE_O = 1'b0
);
   int nak_count = 0;
   // Quarter of a 64 ns serial period
   task automatic qw(input int n);
      repeat (4 * n) @(posedge CLK_I);
   endtask : qw
   task automatic bit_io(input logic b, output logic s);
      SDA_OE_O <= ~b;
      qw(1);
      SCL_O <= 1'b1;
      qw(2);
      s = SDA_I;
      SCL_O <= 1'b0;
      qw(1);
   endtask : bit_io
   // Also serves as repeated start, entered with SCL low
   task automatic start();
      SDA_OE_O <= 1'b0;
      qw(1);
      SCL_O <= 1'b1;
      qw(2);
      SDA_OE_O <= 1'b1;
      qw(2);
      SCL_O <= 1'b0;
      qw(1);
   endtask : start
   task automatic stop();
      SDA_OE_O <= 1'b1;
      qw(1);
      SCL_O <= 1'b1;
      qw(2);
      SDA_OE_O <= 1'b0;
      qw(2);
   endtask : stop
   task automatic put(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      if (s !== 1'b0) nak_count++;
   endtask : put
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (idx == REG_INT) v[INT_RSVD_B] = 1'b0;
      start();
      put({DEV_ADDR, 1'b0});
      put({4'h0, idx});
      put(v);
      stop();
   endtask : wr
   task automatic rd(input logic [3:0] idx, output logic [7:0] d);
      logic s;
      start();
      put({DEV_ADDR, 1'b0});
      put({4'h0, idx});
      start();
      put({DEV_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, s);
      stop();
   endtask : rd
   // Address only; ok is high when the device answered
   task automatic probe(input logic [6:0] a, output logic ok);
      int n;
      n = nak_count;
      start();
      put({a, 1'b0});
      stop();
      ok = (nak_count == n);
      nak_count = n;
   endtask : probe
endmodule : light_prox_host

/* light_prox_control_and_irq_tb.sv */
// Testbench: registers, light window, persistence, interrupt and sleep timing.
// Assumes light_prox_host as the serial master and shortened timing counts.
`timescale 1ns/100ps
module light_prox_control_and_irq_tb;
   import light_prox_pkg::*;
   localparam int LI = 50;
   localparam int PC = 20;
   localparam int SU = 1;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        scl, host_oe, sda_oe, sda_o, int_o, int_oe, ok;
   logic        light_en, light_rng, light_spec, led_dr, led_pulse;
   logic [7:0]  prox_res = 8'h00;
   logic [11:0] vis = 12'h101;
   logic [11:0] ir = 12'hABC;
   wire         sda = ~(host_oe | sda_oe);
   int          bad_count = 0;
   int          checks_done = 0;
   always #2 clk = ~clk;
   // CHIP_ID value is arbitrary
   light_prox_ctrl #(.PROX_CONV_CYC(PC), .LIGHT_INTEG_CYC(LI), .SLEEP_UNIT_CYC(SU),
      .CHIP_ID(8'hA5)) light_prox_ctrl_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
      .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .INT_O(int_o),
      .INT_OE_O(int_oe), .PROX_RESULT_I(prox_res), .LIGHT_VIS_I(vis), .LIGHT_IR_I(ir),
      .LIGHT_ENABLE_O(light_en), .LIGHT_RANGE_O(light_rng), .LIGHT_SPECTRUM_O(light_spec),
      .LED_DRIVE_STRENGTH_O(led_dr), .LED_PULSE_O(led_pulse));
   light_prox_host light_prox_host_inst (.CLK_I(clk), .SDA_I(sda), .SCL_O(scl),
      .SDA_OE_O(host_oe));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      light_prox_host_inst.wr(idx, d);
   endtask : wr
   task automatic rd_chk(input string what, input logic [3:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      light_prox_host_inst.rd(idx, d);
      check(what, {8'h00, exp}, {8'h00, d});
   endtask : rd_chk
   task automatic pulse_run(input logic lvl, output int n);
      n = 0;
      while (led_pulse === lvl && n < 40000) begin
         @(posedge clk);
         n++;
      end
   endtask : pulse_run
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   initial begin
      logic [7:0] rst_tab [7];
      logic [7:0] v;
      int hi, lo, nn;
      rst_tab = '{CFG_RST, INT_RST, PTL_RST, PTH_RST, LTH1_RST, LTH2_RST, LTH3_RST};
      wt(20);
      rst_n <= 1'b1;
      wt(5);
      for (int i = 0; i < 7; i++) rd_chk("reset value", 4'(i + 1), rst_tab[i]);
      rd_chk("chip id", REG_CHIP, 8'hA5);
      rd_chk("unmapped", 4'hB, 8'h00);
      wr(REG_PDAT, 8'h55);
      rd_chk("data read only", REG_PDAT, 8'h00);
      light_prox_host_inst.probe(7'h45, ok);
      check("wrong address ack", 16'h0000, 16'(ok));
      check("open drain outputs", 16'h0000, {14'h0000, sda_o, int_o});
      for (int k = 0; k < 2; k++) begin
         v = (k == 0) ? 8'h0B : 8'h04;
         wr(REG_CFG, v);
         check("cfg pins", {12'h000, v[3:0]}, {12'h000, led_dr, light_en, light_rng, light_spec});
         check("led idle", 16'h0000, 16'(led_pulse));
         rd_chk("cfg readback", REG_CFG, v);
      end
      $display("test registers done");
      wr(REG_LTH2, 8'hF1);
      for (int c = 0; c < 4; c++) begin
         nn = int'(PERS_N[c]);
         vis <= 12'h101;
         wt(60);
         if (c > 0) check("sticky", 16'h0001, 16'(int_oe));
         wr(REG_INT, {5'h00, 2'(c), 1'b0});
         check("flag cleared", 16'h0000, 16'(int_oe));
         vis <= 12'h100;
         if (nn > 1) begin
            wt((nn - 1) * LI);
            check("run short", 16'h0000, 16'(int_oe));
            vis <= 12'h101;
            wt(60);
            vis <= 12'h100;
         end
         wt((nn - 1) * LI);
         check("broken run", 16'h0000, 16'(int_oe));
         wt(55);
         check("light flag", 16'h0001, 16'(int_oe));
      end
      rd_chk("visible low", REG_LDT1, 8'h00);
      rd_chk("visible high", REG_LDT2, 8'h01);
      wr(REG_CFG, 8'h05);
      wt(60);
      rd_chk("infrared low", REG_LDT1, 8'hBC);
      rd_chk("infrared high", REG_LDT2, 8'h0A);
      wr(REG_INT, 8'h00);
      wr(REG_LTH2, 8'hD1);
      wr(REG_LTH3, 8'hAB);
      wt(60);
      check("below light high", 16'h0000, 16'(int_oe));
      wr(REG_LTH2, 8'hC1);
      wt(60);
      check("at light high", 16'h0001, 16'(int_oe));
      wr(REG_CFG, 8'h00);
      wr(REG_INT, 8'h00);
      wt(200);
      check("light off", 16'h0000, 16'(int_oe));
      $display("test light done");
      wr(REG_PTL, 8'h20);
      wr(REG_PTH, 8'h80);
      prox_res <= 8'h7F;
      wr(REG_CFG, 8'hF0);
      wt(100);
      check("below high", 16'h0000, 16'(int_oe));
      prox_res <= 8'h80;
      wt(45);
      check("near", 16'h0001, 16'(int_oe));
      rd_chk("near flag", REG_INT, 8'h80);
      rd_chk("prox data", REG_PDAT, 8'h80);
      prox_res <= 8'h21;
      wt(100);
      check("above low", 16'h0001, 16'(int_oe));
      prox_res <= 8'h20;
      wt(45);
      check("far", 16'h0000, 16'(int_oe));
      wr(REG_INT, 8'h20);
      prox_res <= 8'h90;
      wt(3 * PC);
      check("near run short", 16'h0000, 16'(int_oe));
      wt(2 * PC);
      check("near persist", 16'h0001, 16'(int_oe));
      prox_res <= 8'h20;
      wt(3 * PC);
      check("far run short", 16'h0001, 16'(int_oe));
      wt(2 * PC);
      check("far persist", 16'h0000, 16'(int_oe));
      prox_res <= 8'h90;
      wt(100);
      wr(REG_INT, 8'h81);
      check("and one flag", 16'h0000, 16'(int_oe));
      wr(REG_CFG, 8'hF4);
      wt(60);
      check("and both flags", 16'h0001, 16'(int_oe));
      $display("test proximity done");
      for (int code = 6; code >= 0; code--) begin
         wr(REG_CFG, {1'b1, 3'(code), 4'h0});
         pulse_run(1'b1, hi);
         pulse_run(1'b0, lo);
         pulse_run(1'b1, hi);
         pulse_run(1'b0, lo);
         check("conversion width", 16'(PC), 16'(hi));
         check("sleep width", 16'(SLEEP_UNITS[code] * SU), 16'(lo));
      end
      $display("test sleep done");
      check("missing acks", 16'h0000, 16'(light_prox_host_inst.nak_count));
      close_out();
   end
   initial begin
      wt(90000);
      bad_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      close_out();
   end
endmodule : light_prox_control_and_irq_tb
